// ===== verilog/msr_top.sv
// Meter status reporting: status byte, event registers, output buffer,
// reading memory fetch, statistics and error queries over AHB-Lite.
// Assumes one clock, synchronous inputs and a single AHB-Lite master.
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`default_nettype none
`include "msr_map.svh"
module msr_top #(
    parameter bit SMALL_VARIANT = 1'b1
) (
    input  wire logic               CLK_SYS,
    input  wire logic               RESET_N,
    input  wire logic               HSEL,
    input  wire logic [31:0]        HADDR,
    input  wire logic [1:0]         HTRANS,
    input  wire logic               HWRITE,
    input  wire logic [2:0]         HSIZE,
    input  wire logic [31:0]        HWDATA,
    input  wire logic               HREADY,
    output var  logic [31:0]        HRDATA,
    output var  logic               HREADYOUT,
    output var  logic               HRESP,
    input  wire logic               READING_VALID,
    input  wire msr_pkg::msr_word_t READING_DATA,
    input  wire logic [7:0]         STD_EVENT_IN,
    input  wire logic [15:0]        QUES_EVENT_IN,
    input  wire logic               SYS_ERR_VALID,
    input  wire msr_pkg::msr_word_t SYS_ERR_CODE,
    output var  logic               IRQ
);
    import msr_pkg::*;

    msr_stat_if st ();

    // Bus phase tracking
    logic          ph_wr_reg, ph_wr_next;
    logic [7:0]    ph_addr_reg, ph_addr_next;
    logic [31:0]   hrdata_reg, hrdata_next;
    logic          addr_take;
    logic          rd_take;
    logic          pop;
    logic [7:0]    wr_sel;

    // Status state
    logic [7:0]    stb_reg, stb_next;
    logic [7:0]    spoll_reg, spoll_next;
    logic [7:0]    sre_reg, sre_next;
    logic [7:0]    esr_reg, esr_next;
    logic [7:0]    ese_reg, ese_next;
    logic [15:0]   qev_reg, qev_next;
    logic [15:0]   qen_reg, qen_next;
    logic [3:0]    int_reg, int_next;
    logic [3:0]    msk_reg, msk_next;
    logic          irq_reg, irq_next;
    logic          ctrl_math_reg, ctrl_math_next;
    logic [7:0]    stb_low;
    logic [3:0]    int_ev;

    // Output buffer, memory, fetch and error state
    msr_word_t     out_reg, out_next;
    logic          out_vld_reg, out_vld_next;
    msr_cnt_t      cnt_reg, cnt_next;
    msr_cnt_t      ptr_reg, ptr_next;
    msr_fetch_st_t fst_reg, fst_next;
    msr_word_t     err_reg, err_next;
    logic          err_vld_reg, err_vld_next;
    logic          fetch_done;
    logic          query_ld;
    msr_word_t     query_val;
    logic          mem_wr;
    msr_word_t     mem_rd;
    logic [5:0]    cmd;

    assign addr_take = HSEL && HTRANS[1] && HREADY;
    assign rd_take   = addr_take && !HWRITE;
    assign pop       = rd_take && (HADDR[7:0] == `MSR_OFF_OUT);
    assign wr_sel    = ph_wr_reg ? ph_addr_reg : 8'hff;
    assign cmd       = (wr_sel == `MSR_OFF_CMD) ? HWDATA[5:0] : 6'h00;
    assign mem_wr    = READING_VALID && (cnt_reg < 5'(`MSR_MEM_DEPTH));

    assign st.sample_valid = mem_wr;
    assign st.sample       = READING_DATA;
    assign st.clear        = cmd[`MSR_CMD_CLEAR];
    assign st.math_en      = ctrl_math_reg;

    msr_mem u_mem (
        .clk     (CLK_SYS),
        .rst_n   (RESET_N),
        .wr_en   (mem_wr),
        .wr_addr (cnt_reg[3:0]),
        .wr_data (READING_DATA),
        .rd_addr (ptr_reg[3:0]),
        .rd_data (mem_rd)
    );

    msr_stats u_stats (
        .clk   (CLK_SYS),
        .rst_n (RESET_N),
        .st    (st.calc)
    );

    // Bus slave: zero wait states, read data registered at address phase
    always_comb begin
        ph_wr_next   = addr_take && HWRITE;
        ph_addr_next = addr_take ? HADDR[7:0] : ph_addr_reg;
        hrdata_next  = hrdata_reg;
        if (rd_take) begin
            case (HADDR[7:0])
                `MSR_OFF_STB:     hrdata_next = {24'h0, stb_reg};
                `MSR_OFF_SPOLL:   hrdata_next = {24'h0, spoll_reg};
                `MSR_OFF_SRE:     hrdata_next = {24'h0, sre_reg};
                `MSR_OFF_ESR:     hrdata_next = {24'h0, esr_reg};
                `MSR_OFF_ESE:     hrdata_next = {24'h0, ese_reg};
                `MSR_OFF_QEV:     hrdata_next = {16'h0, qev_reg};
                `MSR_OFF_QEN:     hrdata_next = {16'h0, qen_reg};
                `MSR_OFF_INT_ST:  hrdata_next = {28'h0, int_reg};
                `MSR_OFF_INT_MSK: hrdata_next = {28'h0, msk_reg};
                `MSR_OFF_OUT:     hrdata_next = {15'h0, out_vld_reg,
                                                 out_reg};
                `MSR_OFF_CTRL:    hrdata_next = {31'h0, ctrl_math_reg};
                `MSR_OFF_COUNT:   hrdata_next = {27'h0, cnt_reg};
                `MSR_OFF_ERR:     hrdata_next = {15'h0, err_vld_reg,
                                                 err_reg};
                default:          hrdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            ph_wr_reg   <= 1'b0;
            ph_addr_reg <= 8'h00;
            hrdata_reg  <= 32'h0;
        end else begin
            ph_wr_reg   <= ph_wr_next;
            ph_addr_reg <= ph_addr_next;
            hrdata_reg  <= hrdata_next;
        end
    end

    // Event registers, masks, status byte, serial poll and interrupt
    always_comb begin
        sre_next = (wr_sel == `MSR_OFF_SRE) ? HWDATA[7:0] : sre_reg;
        ese_next = (wr_sel == `MSR_OFF_ESE) ? HWDATA[7:0] : ese_reg;
        qen_next = (wr_sel == `MSR_OFF_QEN) ? HWDATA[15:0] : qen_reg;
        msk_next = (wr_sel == `MSR_OFF_INT_MSK) ? HWDATA[3:0] : msk_reg;
        ctrl_math_next = (wr_sel == `MSR_OFF_CTRL) ?
                         HWDATA[`MSR_CTRL_MATH] : ctrl_math_reg;
        // Write one to clear; a new event in the same cycle wins
        esr_next = (esr_reg & ~((wr_sel == `MSR_OFF_ESR) ?
                   HWDATA[7:0] : 8'h00)) | STD_EVENT_IN;
        qev_next = (qev_reg & ~((wr_sel == `MSR_OFF_QEV) ?
                   HWDATA[15:0] : 16'h0000)) | QUES_EVENT_IN;
        stb_low = 8'h00;
        stb_low[`MSR_STB_QUES] = |(qev_reg & qen_reg);
        stb_low[`MSR_STB_MAV]  = out_vld_reg;
        stb_low[`MSR_STB_ESB]  = |(esr_reg & ese_reg);
        stb_next = stb_low;
        stb_next[`MSR_STB_RQS] = |(stb_low & sre_reg);
        // Small variant hides bits not enabled for service request, except RQS
        spoll_next = SMALL_VARIANT ? (stb_next & (sre_reg |
                     (8'h01 << `MSR_STB_RQS))) : stb_next;
        int_ev = 4'h0;
        int_ev[`MSR_INT_QUES]  = stb_next[`MSR_STB_QUES] &
                                 ~stb_reg[`MSR_STB_QUES];
        int_ev[`MSR_INT_MAV]   = stb_next[`MSR_STB_MAV] &
                                 ~stb_reg[`MSR_STB_MAV];
        int_ev[`MSR_INT_ESB]   = stb_next[`MSR_STB_ESB] &
                                 ~stb_reg[`MSR_STB_ESB];
        int_ev[`MSR_INT_FETCH] = fetch_done;
        int_next = (int_reg & ~((wr_sel == `MSR_OFF_INT_ST) ?
                   HWDATA[3:0] : 4'h0)) | int_ev;
        irq_next = |(int_reg & msk_reg);
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            sre_reg       <= 8'h00;
            ese_reg       <= 8'h00;
            qen_reg       <= 16'h0000;
            msk_reg       <= 4'h0;
            ctrl_math_reg <= 1'b0;
            esr_reg       <= 8'h00;
            qev_reg       <= 16'h0000;
            stb_reg       <= `MSR_RESET_STB;
            spoll_reg     <= `MSR_RESET_STB;
            int_reg       <= 4'h0;
            irq_reg       <= 1'b0;
        end else begin
            sre_reg       <= sre_next;
            ese_reg       <= ese_next;
            qen_reg       <= qen_next;
            msk_reg       <= msk_next;
            ctrl_math_reg <= ctrl_math_next;
            esr_reg       <= esr_next;
            qev_reg       <= qev_next;
            stb_reg       <= stb_next;
            spoll_reg     <= spoll_next;
            int_reg       <= int_next;
            irq_reg       <= irq_next;
        end
    end

    // Queries, fetch sequencer, output buffer, error entry
    always_comb begin
        query_ld  = 1'b0;
        query_val = '0;
        if (cmd[`MSR_CMD_ERR]) begin
            query_ld  = 1'b1;
            query_val = err_reg;
        end else if (ctrl_math_reg && cmd[`MSR_CMD_AVG]) begin
            query_ld  = 1'b1;
            query_val = st.avg;
        end else if (ctrl_math_reg && cmd[`MSR_CMD_MAX]) begin
            query_ld  = 1'b1;
            query_val = st.max_val;
        end else if (ctrl_math_reg && cmd[`MSR_CMD_MIN]) begin
            query_ld  = 1'b1;
            query_val = st.min_val;
        end
        fst_next   = fst_reg;
        ptr_next   = ptr_reg;
        fetch_done = 1'b0;
        out_next     = out_reg;
        out_vld_next = out_vld_reg && !pop;
        case (fst_reg)
            FETCH_IDLE: begin
                if (cmd[`MSR_CMD_FETCH] && cnt_reg != '0) begin
                    ptr_next = '0;
                    fst_next = FETCH_READ;
                end
            end
            FETCH_READ: begin
                fst_next = FETCH_LOAD;
            end
            FETCH_LOAD: begin
                if (!out_vld_reg && !query_ld) begin
                    out_next     = mem_rd;
                    out_vld_next = 1'b1;
                    ptr_next     = ptr_reg + 5'h01;
                    if (ptr_reg + 5'h01 >= cnt_reg) begin
                        fst_next   = FETCH_IDLE;
                        fetch_done = 1'b1;
                    end else begin
                        fst_next = FETCH_READ;
                    end
                end
            end
            default: begin
                fst_next = FETCH_IDLE;
            end
        endcase
        if (query_ld) begin
            out_next     = query_val;
            out_vld_next = 1'b1;
        end
        cnt_next = cmd[`MSR_CMD_CLEAR] ? '0 :
                   (mem_wr ? cnt_reg + 5'h01 : cnt_reg);
        // Error query clears the entry unless a new error arrives
        err_vld_next = SYS_ERR_VALID ||
                       (err_vld_reg && !cmd[`MSR_CMD_ERR]);
        err_next = SYS_ERR_VALID ? SYS_ERR_CODE :
                   (cmd[`MSR_CMD_ERR] ? '0 : err_reg);
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            fst_reg     <= FETCH_IDLE;
            ptr_reg     <= '0;
            out_reg     <= '0;
            out_vld_reg <= 1'b0;
            cnt_reg     <= '0;
            err_reg     <= '0;
            err_vld_reg <= 1'b0;
        end else begin
            fst_reg     <= fst_next;
            ptr_reg     <= ptr_next;
            out_reg     <= out_next;
            out_vld_reg <= out_vld_next;
            cnt_reg     <= cnt_next;
            err_reg     <= err_next;
            err_vld_reg <= err_vld_next;
        end
    end

    assign HRDATA    = hrdata_reg;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign IRQ       = irq_reg;
endmodule
`default_nettype wire

// ===== verilog/msr_map.svh
// Register map, field positions and sizes of the meter status block.
// Assumes inclusion by every design file that decodes registers.
`ifndef MSR_MAP_SVH
`define MSR_MAP_SVH

`define MSR_OFF_STB      8'h00
`define MSR_OFF_SPOLL    8'h04
`define MSR_OFF_SRE      8'h08
`define MSR_OFF_ESR      8'h0c
`define MSR_OFF_ESE      8'h10
`define MSR_OFF_QEV      8'h14
`define MSR_OFF_QEN      8'h18
`define MSR_OFF_INT_ST   8'h1c
`define MSR_OFF_INT_MSK  8'h20
`define MSR_OFF_CMD      8'h24
`define MSR_OFF_OUT      8'h28
`define MSR_OFF_CTRL     8'h2c
`define MSR_OFF_COUNT    8'h30
`define MSR_OFF_ERR      8'h34

`define MSR_STB_QUES     3
`define MSR_STB_MAV      4
`define MSR_STB_ESB      5
`define MSR_STB_RQS      6

`define MSR_CMD_FETCH    0
`define MSR_CMD_AVG      1
`define MSR_CMD_MAX      2
`define MSR_CMD_MIN      3
`define MSR_CMD_ERR      4
`define MSR_CMD_CLEAR    5

`define MSR_INT_QUES     0
`define MSR_INT_MAV      1
`define MSR_INT_ESB      2
`define MSR_INT_FETCH    3

`define MSR_CTRL_MATH    0
`define MSR_MEM_DEPTH    16
`define MSR_RESET_STB    8'h00

`endif

// ===== verilog/msr_pkg.sv
// Types shared by the meter status block modules.
// Assumes msr_map.svh for the numeric layout.
`default_nettype none
package msr_pkg;
    typedef logic [15:0] msr_word_t;
    typedef logic [4:0]  msr_cnt_t;
    typedef logic [3:0]  msr_idx_t;
    typedef enum logic [1:0] {
        FETCH_IDLE,
        FETCH_READ,
        FETCH_LOAD
    } msr_fetch_st_t;
endpackage
`default_nettype wire

// ===== verilog/msr_stat_if.sv
// Carrier between the status core and the reading statistics unit.
// Assumes one clock domain shared by both ends.
`default_nettype none
interface msr_stat_if;
    import msr_pkg::*;
    logic      sample_valid;
    msr_word_t sample;
    logic      clear;
    logic      math_en;
    msr_word_t avg;
    msr_word_t min_val;
    msr_word_t max_val;
    modport core (output sample_valid, sample, clear, math_en,
                  input  avg, min_val, max_val);
    modport calc (input  sample_valid, sample, clear, math_en,
                  output avg, min_val, max_val);
endinterface
`default_nettype wire

// ===== verilog/msr_mem.sv
// Reading memory: one write port, registered read data.
// Assumes the caller keeps addresses inside the depth.
`default_nettype none
`include "msr_map.svh"
module msr_mem (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               wr_en,
    input  wire msr_pkg::msr_idx_t  wr_addr,
    input  wire msr_pkg::msr_word_t wr_data,
    input  wire msr_pkg::msr_idx_t  rd_addr,
    output var  msr_pkg::msr_word_t rd_data
);
    import msr_pkg::*;
    msr_word_t mem [`MSR_MEM_DEPTH];
    msr_word_t rd_data_reg;
    msr_word_t rd_data_next;

    always_comb begin
        rd_data_next = mem[rd_addr];
    end

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= '0;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;
endmodule
`default_nettype wire

// ===== verilog/msr_stats.sv
// Running average, minimum and maximum of readings stored while math is enabled.
// Assumes unsigned readings and at most MSR_MEM_DEPTH samples.
`default_nettype none
`include "msr_map.svh"
module msr_stats (
    input  wire logic clk,
    input  wire logic rst_n,
    msr_stat_if.calc  st
);
    import msr_pkg::*;
    logic [19:0] sum_reg, sum_next;
    msr_cnt_t    cnt_reg, cnt_next;
    msr_word_t   min_reg, min_next;
    msr_word_t   max_reg, max_next;
    msr_word_t   avg_reg, avg_next;

    always_comb begin
        sum_next = sum_reg;
        cnt_next = cnt_reg;
        min_next = min_reg;
        max_next = max_reg;
        avg_next = (cnt_reg == '0) ? '0 :
                   16'(sum_reg / {15'h0000, cnt_reg});
        if (st.clear) begin
            sum_next = '0;
            cnt_next = '0;
            min_next = 16'hffff;
            max_next = '0;
        end else if (st.sample_valid && st.math_en) begin
            sum_next = sum_reg + {4'h0, st.sample};
            cnt_next = cnt_reg + 5'h01;
            if (st.sample < min_reg) begin
                min_next = st.sample;
            end
            if (st.sample > max_reg) begin
                max_next = st.sample;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sum_reg <= '0;
            cnt_reg <= '0;
            min_reg <= 16'hffff;
            max_reg <= '0;
            avg_reg <= '0;
        end else begin
            sum_reg <= sum_next;
            cnt_reg <= cnt_next;
            min_reg <= min_next;
            max_reg <= max_next;
            avg_reg <= avg_next;
        end
    end

    assign st.avg     = avg_reg;
    assign st.min_val = (cnt_reg == '0) ? '0 : min_reg;
    assign st.max_val = max_reg;
endmodule
`default_nettype wire

// ===== tb/msr_monitor.sv
// Port-level checks of the meter status block, bound into msr_top.
// Assumes one AHB-Lite master with HREADY fed back from HREADYOUT.
`default_nettype none
`include "msr_map.svh"
module msr_monitor #(
    parameter bit SMALL_VARIANT = 1'b1
) (
    input wire logic        CLK_SYS,
    input wire logic        RESET_N,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic [7:0]  STD_EVENT_IN,
    input wire logic        IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       tk;
    logic       wph_reg,   wph_next,   pend_reg,  pend_next;
    logic [7:0] wa_reg,    wa_next,    sre_reg,   sre_next;
    logic [7:0] ese_reg,   ese_next;
    logic [3:0] msk_reg,   msk_next;
    logic [2:0] quiet_reg, quiet_next, age_reg,   age_next;

    // Shadows of the mask registers and age of an enabled event
    assign tk = HSEL && HTRANS[1] && HREADY;
    always_comb begin
        wph_next   = (wph_reg && !HREADY) || (tk && HWRITE);
        wa_next    = tk ? HADDR[7:0] : wa_reg;
        sre_next   = sre_reg;
        ese_next   = ese_reg;
        msk_next   = msk_reg;
        if (wph_reg && HREADY) begin
            if (wa_reg == `MSR_OFF_SRE) sre_next = HWDATA[7:0];
            if (wa_reg == `MSR_OFF_ESE) ese_next = HWDATA[7:0];
            if (wa_reg == `MSR_OFF_INT_MSK) msk_next = HWDATA[3:0];
        end
        quiet_next = quiet_reg + {2'h0, quiet_reg != 3'h7};
        age_next   = age_reg + {2'h0, age_reg != 3'h7};
        pend_next  = pend_reg;
        if (tk && HWRITE) begin
            quiet_next = 3'h0;
            pend_next  = 1'b0;
        end else if ((STD_EVENT_IN & ese_reg) != 8'h0 &&
                     quiet_reg >= 3'h2) begin
            pend_next = 1'b1;
            age_next  = 3'h0;
        end
    end
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            {wph_reg, wa_reg, sre_reg, ese_reg, msk_reg} <= '0;
            {quiet_reg, age_reg, pend_reg} <= '0;
        end else begin
            {wph_reg, wa_reg, sre_reg, ese_reg, msk_reg} <=
                {wph_next, wa_next, sre_next, ese_next, msk_next};
            {quiet_reg, age_reg, pend_reg} <=
                {quiet_next, age_next, pend_next};
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    sequence rd_at(logic [7:0] a);
        tk && !HWRITE && HADDR[7:0] == a;
    endsequence

    ready_always_a:
    assert property (HREADYOUT) else $error("wait state inserted");
    resp_okay_a:
    assert property (!HRESP) else $error("error response given");
    stb_layout_a:
    assert property (rd_at(`MSR_OFF_STB) |=>
        HRDATA[31:7] == 25'h0 && HRDATA[2:0] == 3'h0)
        else $error("status byte has stray bits");
    spoll_mask_a:
    assert property (rd_at(`MSR_OFF_SPOLL) ##0 quiet_reg >= 3'h4 |=>
        (HRDATA & ~{24'h0, SMALL_VARIANT ? sre_reg | 8'h40 : 8'hff})
        == 32'h0) else $error("poll shows a disabled bit");
    esb_flag_a:
    assert property (rd_at(`MSR_OFF_STB) ##0 pend_reg && age_reg >= 3'h3
        |=> HRDATA[`MSR_STB_ESB]) else $error("event summary missing");
    irq_mask_a:
    assert property ((msk_reg == 4'h0) [*2] |-> !IRQ)
        else $error("interrupt with all sources masked");
    unmapped_zero_a:
    assert property (tk && !HWRITE && HADDR[7:0] >= 8'h38 |=>
        HRDATA == 32'h0) else $error("unmapped read not zero");
    reset_quiet_a:
    assert property ($rose(RESET_N) |-> !IRQ && HRDATA == 32'h0)
        else $error("outputs not quiet after reset");
endmodule
bind msr_top msr_monitor #(.SMALL_VARIANT(SMALL_VARIANT)) msr_monitor_i (
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .STD_EVENT_IN(STD_EVENT_IN), .IRQ(IRQ)
);
`default_nettype wire

// ===== tb/msr_front_model.sv
// Measurement side: readings, event pulses and error reports.
// Assumes its tasks are called from one bench thread at a time.
`default_nettype none
module msr_front_model (
    input  wire logic               clk,
    output var  logic               reading_valid,
    output var  msr_pkg::msr_word_t reading_data,
    output var  logic [7:0]         std_event,
    output var  logic [15:0]        ques_event,
    output var  logic               err_valid,
    output var  msr_pkg::msr_word_t err_code
);
    timeunit 1ns;
    timeprecision 1ns;
    import msr_pkg::*;
    initial begin
        {reading_valid, reading_data, std_event} = '0;
        {ques_event, err_valid, err_code} = '0;
    end
    // Data lines show the inverse once the pulse is over
    task automatic reading(input msr_word_t v);
        @(posedge clk);
        reading_valid <= 1'b1;
        reading_data  <= v;
        @(posedge clk);
        reading_valid <= 1'b0;
        reading_data  <= ~v;
    endtask
    task automatic std_ev(input logic [7:0] b);
        @(posedge clk);
        std_event <= b;
        @(posedge clk);
        std_event <= 8'h0;
    endtask
    task automatic ques_ev(input logic [15:0] b);
        @(posedge clk);
        ques_event <= b;
        @(posedge clk);
        ques_event <= 16'h0;
    endtask
    task automatic sys_err(input msr_word_t c);
        @(posedge clk);
        err_valid <= 1'b1;
        err_code  <= c;
        @(posedge clk);
        err_valid <= 1'b0;
        err_code  <= ~c;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench: host sequences over AHB-Lite on msr_top.
// Assumes msr_front_model drives the measurement-side inputs.
`default_nettype none
`include "msr_map.svh"
`define CHK(g, e) \
    begin \
        n_compared++; \
        if ((g) !== (e)) begin \
            error_cnt++; \
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import msr_pkg::*;
    logic        clk_sys = 1'b0, reset_n = 1'b0, hsel = 1'b0;
    logic        hwrite  = 1'b0, hreadyout, hresp, irq;
    logic [31:0] haddr   = 32'h0, hwdata = 32'h0, hrdata, d;
    logic [1:0]  htrans  = 2'h0;
    logic [2:0]  hsize   = 3'h0;
    logic        rd_valid, err_valid;
    msr_word_t   rd_data, err_code;
    logic [7:0]  std_ev;
    logic [15:0] ques_ev;
    int          error_cnt = 0, n_compared = 0, cycles = 0;
    msr_word_t   rdg [3] = '{16'h0010, 16'h0030, 16'h0005};
    msr_word_t   stv [3] = '{16'h0017, 16'h0030, 16'h0005};

    always #10 clk_sys = ~clk_sys;
    msr_top #(.SMALL_VARIANT(1'b1)) msr_top_i (
        .CLK_SYS(clk_sys), .RESET_N(reset_n), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .READING_VALID(rd_valid),
        .READING_DATA(rd_data), .STD_EVENT_IN(std_ev),
        .QUES_EVENT_IN(ques_ev), .SYS_ERR_VALID(err_valid),
        .SYS_ERR_CODE(err_code), .IRQ(irq));
    msr_front_model msr_front_model_i (
        .clk(clk_sys), .reading_valid(rd_valid), .reading_data(rd_data),
        .std_event(std_ev), .ques_event(ques_ev),
        .err_valid(err_valid), .err_code(err_code));

    task automatic conclude;
        $display("errors=%0d compared=%0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            conclude();
        end
    end
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] v);
        @(posedge clk_sys);
        {hsel, hwrite, htrans} <= {1'b1, w, 2'h2};
        hsize <= 3'h2;
        haddr <= {24'h0, a};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        {hsel, htrans} <= 3'h0;
        hsize  <= 3'h0;
        haddr  <= ~{24'h0, a};
        hwdata <= v;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        d = hrdata;
        hwdata <= ~v;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        xfer(a, 1'b1, v);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        `CHK(d, e)
    endtask
    task automatic poll(input logic [7:0] a, input logic [31:0] m);
        for (int k = 0; k < 40; k++) begin
            xfer(a, 1'b0, 32'h0);
            if ((d & m) !== 32'h0) break;
        end
    endtask
    task automatic pause;
        repeat (5) @(posedge clk_sys);
    endtask

    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        chk_rd(`MSR_OFF_STB, 32'h0);
        chk_rd(8'h3c, 32'h0);
        wr(`MSR_OFF_SRE, 32'h20);
        wr(`MSR_OFF_ESE, 32'h01);
        wr(`MSR_OFF_QEN, 32'h0001);
        msr_front_model_i.std_ev(8'h02);
        pause();
        chk_rd(`MSR_OFF_ESR, 32'h02);
        chk_rd(`MSR_OFF_STB, 32'h0);
        wr(`MSR_OFF_ESR, 32'h02);
        chk_rd(`MSR_OFF_ESR, 32'h0);
        msr_front_model_i.std_ev(8'h01);
        poll(`MSR_OFF_STB, 32'h20);
        `CHK(d, 32'h60)
        chk_rd(`MSR_OFF_SPOLL, 32'h60);
        chk_rd(`MSR_OFF_INT_ST, 32'h4);
        `CHK(irq, 1'b0)
        wr(`MSR_OFF_INT_MSK, 32'h4);
        pause();
        `CHK(irq, 1'b1)
        wr(`MSR_OFF_INT_ST, 32'h4);
        pause();
        `CHK(irq, 1'b0)
        msr_front_model_i.ques_ev(16'h0008);
        msr_front_model_i.ques_ev(16'h0001);
        pause();
        chk_rd(`MSR_OFF_QEV, 32'h9);
        chk_rd(`MSR_OFF_STB, 32'h68);
        chk_rd(`MSR_OFF_SPOLL, 32'h60);
        wr(`MSR_OFF_QEN, 32'h0);
        chk_rd(`MSR_OFF_STB, 32'h60);
        wr(`MSR_OFF_CTRL, 32'h1);
        for (int i = 0; i < 3; i++) msr_front_model_i.reading(rdg[i]);
        pause();
        chk_rd(`MSR_OFF_COUNT, 32'h3);
        wr(`MSR_OFF_CMD, 32'h1);
        for (int i = 0; i < 3; i++) begin
            poll(`MSR_OFF_OUT, 32'h10000);
            `CHK(d, {15'h0, 1'b1, rdg[i]})
        end
        pause();
        chk_rd(`MSR_OFF_INT_ST, 32'hb);
        for (int i = 0; i < 3; i++) begin
            wr(`MSR_OFF_CMD, 32'h2 << i);
            pause();
            chk_rd(`MSR_OFF_STB, 32'h70);
            chk_rd(`MSR_OFF_OUT, {15'h0, 1'b1, stv[i]});
        end
        wr(`MSR_OFF_CTRL, 32'h0);
        wr(`MSR_OFF_CMD, 32'h2);
        pause();
        xfer(`MSR_OFF_OUT, 1'b0, 32'h0);
        `CHK(d[16], 1'b0)
        msr_front_model_i.sys_err(16'h0123);
        pause();
        chk_rd(`MSR_OFF_ERR, 32'h10123);
        wr(`MSR_OFF_CMD, 32'h10);
        chk_rd(`MSR_OFF_OUT, 32'h10123);
        xfer(`MSR_OFF_ERR, 1'b0, 32'h0);
        `CHK(d[16], 1'b0)
        wr(`MSR_OFF_CMD, 32'h10);
        chk_rd(`MSR_OFF_OUT, 32'h10000);
        wr(`MSR_OFF_CMD, 32'h20);
        pause();
        chk_rd(`MSR_OFF_COUNT, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
